// ### thsm_regs.svh
/*
 * Constants of the thermometer bus master: opcodes, bit timing and the
 * long clock-low holds. Assumes a 25 MHz system clock (40 ns period).
 */
// Notes on behaviour
// - address zero with write always answered
// - master restarts message after any NACK; code gives up after TRIES attempts
// - PEC is CRC-8, poly x8+x2+x+1
// - every byte sent MSB first
// - data changes in low phase, sampled rising
// - erase cell with 0x0000 before writing
// - master avoids calibration words 0x04..0x0D
// - clock between 10 kHz and 100 kHz
// - clock low over 39 ms leaves PWM
// - sleep by command only, clock high asleep
// - clock low over 8 ms wakes target
`ifndef THSM_REGS_SVH
`define THSM_REGS_SVH
`define THSM_CLK_NS 40
`define THSM_QTR_NS 2500
`define THSM_SDA_DLY_NS 300
`define THSM_REQ_LOW_NS 39000000
`define THSM_WAKE_LOW_NS 8000000
`define THSM_SETTLE_NS 300000000
`define THSM_OPC_EEPROM 4'h1
`define THSM_OPC_RAM 4'h2
`define THSM_OPC_SLEEP 8'hC6
`define THSM_CAL_FIRST 4'h4
`define THSM_CRC_POLY 8'h07
`define THSM_CRC_INIT 8'h00
`endif

// ### thsm_pkg.sv
/*
 * Types of the thermometer bus master.
 * Assumes thsm_regs.svh supplies the numeric constants.
 */
package thsm_pkg;
   // requested operation
   typedef enum logic [2:0] {
      THSM_OP_READ, THSM_OP_WRITE, THSM_OP_SLEEP, THSM_OP_REQUEST,
      THSM_OP_WAKE
   } thsm_op_type;
   // outcome of an operation
   typedef enum logic [1:0] {
      THSM_ST_OK, THSM_ST_NACK, THSM_ST_PEC, THSM_ST_REFUSED
   } thsm_stat_type;
   // sequencer states
   typedef enum logic [2:0] {
      S_IDLE, S_HOLD, S_SETTLE, S_START, S_BIT, S_ACK, S_STOP, S_DONE
   } thsm_state_type;
endpackage : thsm_pkg

// ### thsm_crc8.sv
/*
 * Serial CRC-8 over wire bits, MSB first.
 * Assumes the caller feeds only data bits, never start, stop or ack.
 */
`timescale 1ns/100ps
`include "thsm_regs.svh"
module thsm_crc8 (
   input wire logic ref_clk_in,
   input wire logic nrst_in,
   input wire logic clr_in,
   input wire logic en_in,
   input wire logic bit_in,
   output logic [7:0] crc_out
);
   logic fb; // feedback bit
   assign fb = crc_out[7] ^ bit_in;
   // shift one bit per enable, clear wins
   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         crc_out <= `THSM_CRC_INIT;
      end else if (clr_in) begin
         crc_out <= `THSM_CRC_INIT;
      end else if (en_in) begin
         crc_out <= {crc_out[6:0], 1'b0} ^
            (fb ? `THSM_CRC_POLY : 8'h00);
      end
   end
endmodule : thsm_crc8

// ### thsm_master.sv
/*
 * Bus master for the infrared thermometer: read word, write word with
 * erase, sleep command, and long clock-low request and wake holds.
 * Assumes open-drain pins with pull-ups resolved outside, one master.
 */
`timescale 1ns/100ps
`include "thsm_regs.svh"
module thsm_master import thsm_pkg::*; #(
   parameter int QTR_CYC = (`THSM_QTR_NS + `THSM_CLK_NS - 1) / `THSM_CLK_NS,
   parameter int REQ_CYC = `THSM_REQ_LOW_NS / `THSM_CLK_NS + 1,
   parameter int WAKE_CYC = `THSM_WAKE_LOW_NS / `THSM_CLK_NS + 1,
   parameter int SETTLE_CYC = `THSM_SETTLE_NS / `THSM_CLK_NS,
   parameter int TRIES = 3
) (
   input wire logic ref_clk_in,
   input wire logic nrst_in,
   input wire logic cmd_valid_in,
   output logic cmd_ready_out,
   input wire thsm_op_type cmd_op_in,
   input wire logic [6:0] taddr_in,
   input wire logic ram_sel_in,
   input wire logic [3:0] maddr_in,
   input wire logic [15:0] wdata_in,
   output logic done_out,
   output thsm_stat_type status_out,
   output logic [15:0] rdata_out,
   output logic rdata_err_out,
   output logic asleep_out,
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe_out,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_out
);
   localparam int SDA_DLY =
      (`THSM_SDA_DLY_NS + `THSM_CLK_NS - 1) / `THSM_CLK_NS;
   // refuse rates outside 10..100 kHz and settle, request or try counts beyond their counters
   if (4 * QTR_CYC * `THSM_CLK_NS < 10000 ||
       4 * QTR_CYC * `THSM_CLK_NS > 100000 || SDA_DLY >= QTR_CYC ||
       SETTLE_CYC >= 2**24 || REQ_CYC >= 2**24 || WAKE_CYC < 1 ||
       TRIES < 1 || TRIES > 15) begin : g_chk
      $error("thsm_master: unusable parameter values");
   end

   thsm_state_type state_q; // sequencer state
   thsm_op_type op_q; // latched operation
   thsm_stat_type stat_q; // latched outcome
   logic [1:0] ph_q; // quarter within a bit
   logic [2:0] bit_q; // bit within a byte
   logic [2:0] idx_q; // byte within a message
   logic [3:0] try_q; // attempts made so far
   logic [11:0] div_q; // quarter-period divider
   logic [23:0] cnt_q; // long hold counter
   logic [7:0] shift_q; // byte shifter
   logic [6:0] taddr_q; // target address
   logic [7:0] cmd_q; // command byte
   logic [15:0] wdata_q; // word to write
   logic erase_q; // erase pass pending
   logic bad_q; // nack or pec fault seen
   logic ram_q; // last read was RAM
   logic scl_m_q, scl_s_q, sda_m_q, sda_s_q; // pin synchronisers
   logic qtick, stick, rx, crc_clr, crc_en;
   logic [7:0] crc;

   // byte sent at a given position of the message
   function automatic logic [7:0] tx_byte(input thsm_op_type op,
      input logic [2:0] idx, input logic [7:0] crcv);
      logic [15:0] w;
      w = erase_q ? 16'h0000 : wdata_q;
      tx_byte = crcv; // PEC by default
      if (idx == 3'h0) tx_byte = {taddr_q, 1'b0}; // zero allowed
      else if (idx == 3'h1) tx_byte = cmd_q;
      else if (op == THSM_OP_READ && idx == 3'h2) tx_byte = {taddr_q, 1'b1};
      else if (op == THSM_OP_WRITE && idx == 3'h2) tx_byte = w[7:0];
      else if (op == THSM_OP_WRITE && idx == 3'h3) tx_byte = w[15:8];
   endfunction : tx_byte

   // index of the final byte of each message
   function automatic logic [2:0] last_idx(input thsm_op_type op);
      case (op)
         THSM_OP_READ: last_idx = 3'h5;
         THSM_OP_WRITE: last_idx = 3'h4;
         default: last_idx = 3'h2;
      endcase
   endfunction : last_idx

   assign rx = (op_q == THSM_OP_READ) && (idx_q >= 3'h3);
   assign qtick = (div_q == 12'(QTR_CYC - 1));
   assign stick = (div_q == 12'(SDA_DLY - 1)) && (ph_q == 2'h0);
   assign cmd_ready_out = (state_q == S_IDLE);
   assign scl_out = 1'b0; // open drain: only ever pulls low
   assign sda_out = 1'b0;
   assign crc_clr = (state_q == S_START) && (idx_q == 3'h0);
   assign crc_en = (state_q == S_BIT) && qtick && ph_q == 2'h2 && scl_s_q;
   assign rdata_err_out = ram_q && rdata_out[15];

   // two flops on each pin before any logic looks at it
   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         {scl_m_q, scl_s_q, sda_m_q, sda_s_q} <= 4'hF;
      end else begin
         scl_m_q <= scl_in;
         scl_s_q <= scl_m_q;
         sda_m_q <= sda_in;
         sda_s_q <= sda_m_q;
      end
   end

   // quarter-bit divider, parked while idle so bits start aligned
   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) div_q <= 12'h000;
      else if (state_q == S_IDLE || qtick) div_q <= 12'h000;
      else div_q <= div_q + 12'h001;
   end

   thsm_crc8 u_crc (
      .ref_clk_in(ref_clk_in),
      .nrst_in(nrst_in),
      .clr_in(crc_clr),
      .en_in(crc_en),
      .bit_in(sda_s_q),
      .crc_out(crc)
   );

   // pin drivers; in data and ack bits sda moves a few cycles after scl falls, start and stop move it with scl high
   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         scl_oe_out <= 1'b0;
         sda_oe_out <= 1'b0;
      end else begin
         case (state_q)
            S_HOLD: begin // long low, data line left alone
               scl_oe_out <= 1'b1;
               sda_oe_out <= 1'b0;
            end
            S_START: begin // start or repeated start
               if (qtick && ph_q == 2'h0) sda_oe_out <= 1'b0;
               if (qtick && ph_q == 2'h1) scl_oe_out <= 1'b0;
               if (qtick && ph_q == 2'h2) sda_oe_out <= 1'b1;
               if (qtick && ph_q == 2'h3) scl_oe_out <= 1'b1;
            end
            S_BIT, S_ACK: begin
               if (stick && state_q == S_BIT) begin
                  sda_oe_out <= !rx && !shift_q[7]; // MSB first
               end else if (stick) begin
                  // ack every word byte, nack the PEC
                  sda_oe_out <= rx && (idx_q != last_idx(op_q));
               end
               if (qtick && ph_q == 2'h1) scl_oe_out <= 1'b0;
               if (qtick && ph_q == 2'h3) scl_oe_out <= 1'b1;
            end
            S_STOP: begin
               if (stick) sda_oe_out <= 1'b1;
               if (qtick && ph_q == 2'h1) scl_oe_out <= 1'b0;
               if (qtick && ph_q == 2'h2) sda_oe_out <= 1'b0;
            end
            default: begin // idle keeps clock high, also asleep
               scl_oe_out <= 1'b0;
               sda_oe_out <= 1'b0;
            end
         endcase
      end
   end

   // message sequencer
   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         state_q <= S_IDLE;
         op_q <= THSM_OP_READ;
         stat_q <= THSM_ST_OK;
         {ph_q, bit_q, idx_q, try_q} <= 12'h000;
         cnt_q <= 24'h000000;
         shift_q <= 8'h00;
         taddr_q <= 7'h00;
         cmd_q <= 8'h00;
         wdata_q <= 16'h0000;
         {erase_q, bad_q, ram_q, done_out, asleep_out} <= 5'h00;
         rdata_out <= 16'h0000;
      end else begin
         done_out <= 1'b0;
         case (state_q)
            S_IDLE: if (cmd_valid_in) begin
               op_q <= cmd_op_in;
               taddr_q <= taddr_in;
               wdata_q <= wdata_in;
               {ph_q, idx_q, try_q, cnt_q} <= 33'h0;
               stat_q <= THSM_ST_OK;
               bad_q <= 1'b0;
               erase_q <= (cmd_op_in == THSM_OP_WRITE);
               case (cmd_op_in)
                  THSM_OP_READ: begin
                     cmd_q <= {ram_sel_in ? `THSM_OPC_RAM : `THSM_OPC_EEPROM,
                        maddr_in};
                     ram_q <= ram_sel_in;
                     state_q <= S_START;
                  end
                  THSM_OP_WRITE: begin
                     cmd_q <= {`THSM_OPC_EEPROM, maddr_in};
                     if (maddr_in >= `THSM_CAL_FIRST) begin
                        stat_q <= THSM_ST_REFUSED;
                        state_q <= S_DONE;
                     end else state_q <= S_START;
                  end
                  THSM_OP_SLEEP: begin
                     cmd_q <= `THSM_OPC_SLEEP;
                     state_q <= S_START;
                  end
                  default: state_q <= S_HOLD;
               endcase
            end
            S_HOLD: begin // wake and request both only need time
               cnt_q <= cnt_q + 24'h1;
               if (cnt_q == 24'((op_q == THSM_OP_WAKE) ? WAKE_CYC - 1
                  : REQ_CYC - 1)) begin
                  cnt_q <= 24'h0;
                  state_q <= (op_q == THSM_OP_WAKE) ? S_SETTLE : S_DONE;
               end
            end
            S_SETTLE: begin // data not valid right after waking
               cnt_q <= cnt_q + 24'h1;
               asleep_out <= 1'b0;
               if (cnt_q == 24'(SETTLE_CYC - 1)) state_q <= S_DONE;
            end
            S_START: if (qtick) begin
               ph_q <= ph_q + 2'h1;
               if (ph_q == 2'h3) begin
                  state_q <= S_BIT;
                  bit_q <= 3'h0;
                  shift_q <= tx_byte(op_q, idx_q, crc);
               end
            end
            S_BIT: if (qtick && !(ph_q == 2'h2 && !scl_s_q)) begin
               // a held-low clock stretches the high quarter
               ph_q <= ph_q + 2'h1;
               if (ph_q == 2'h2) shift_q <= {shift_q[6:0], sda_s_q};
               if (ph_q == 2'h3) begin
                  bit_q <= bit_q + 3'h1;
                  if (bit_q == 3'h7) state_q <= S_ACK;
               end
            end
            S_ACK: if (qtick && !(ph_q == 2'h2 && !scl_s_q)) begin
               ph_q <= ph_q + 2'h1;
               if (ph_q == 2'h2 && !rx && sda_s_q) begin
                  bad_q <= 1'b1; // target silent or refused
                  stat_q <= THSM_ST_NACK;
               end
               if (ph_q == 2'h3) begin
                  if (op_q == THSM_OP_READ && idx_q == 3'h3)
                     rdata_out[7:0] <= shift_q;
                  if (op_q == THSM_OP_READ && idx_q == 3'h4)
                     rdata_out[15:8] <= shift_q;
                  if (bad_q || idx_q == last_idx(op_q)) begin
                     state_q <= S_STOP;
                     if (rx && crc != 8'h00) begin
                        bad_q <= 1'b1;
                        stat_q <= THSM_ST_PEC;
                     end
                  end else begin
                     idx_q <= idx_q + 3'h1;
                     bit_q <= 3'h0;
                     if (op_q == THSM_OP_READ && idx_q == 3'h1) begin
                        state_q <= S_START; // repeated start
                     end else begin
                        state_q <= S_BIT;
                        shift_q <= tx_byte(op_q, idx_q + 3'h1, crc);
                     end
                  end
               end
            end
            S_STOP: if (qtick) begin
               ph_q <= ph_q + 2'h1;
               if (ph_q == 2'h3) begin
                  idx_q <= 3'h0;
                  if (bad_q && try_q < 4'(TRIES - 1)) begin
                     try_q <= try_q + 4'h1;
                     bad_q <= 1'b0;
                     stat_q <= THSM_ST_OK;
                     state_q <= S_START;
                  end else if (!bad_q && erase_q && wdata_q != 16'h0) begin
                     erase_q <= 1'b0; // erased, now the real word
                     try_q <= 4'h0;
                     state_q <= S_START;
                  end else state_q <= S_DONE;
               end
            end
            default: begin // S_DONE
               done_out <= 1'b1;
               if (op_q == THSM_OP_SLEEP && stat_q == THSM_ST_OK)
                  asleep_out <= 1'b1;
               state_q <= S_IDLE;
            end
         endcase
      end
   end
   assign status_out = stat_q;

   sequence s_nack;
      state_q == S_ACK && qtick && ph_q == 2'h2 && scl_s_q && !rx && sda_s_q;
   endsequence
   sequence s_long_low;
      state_q == S_HOLD && op_q == THSM_OP_REQUEST && cnt_q == 24'h0;
   endsequence

   AST_SDA_STILL_HIGH: assert property (@(posedge ref_clk_in)
      disable iff (!nrst_in) (state_q == S_BIT && ph_q >= 2'h2)
      |-> $stable(sda_oe_out)) else $error("sda moved with scl high");
   AST_SDA_LATE: assert property (@(posedge ref_clk_in)
      disable iff (!nrst_in) ($changed(sda_oe_out) && state_q == S_BIT)
      |-> scl_oe_out && ph_q == 2'h0) else $error("sda moved off slot");
   AST_MSB_FIRST: assert property (@(posedge ref_clk_in)
      disable iff (!nrst_in) (state_q == S_BIT && stick && !rx)
      |=> sda_oe_out == !$past(shift_q[7])) else $error("bit order");
   AST_ACK_AFTER8: assert property (@(posedge ref_clk_in)
      disable iff (!nrst_in) (state_q == S_BIT && qtick && ph_q == 2'h3
      && bit_q == 3'h7) |=> state_q == S_ACK) else $error("no ack slot");
   AST_NACK_STOPS: assert property (@(posedge ref_clk_in)
      disable iff (!nrst_in) s_nack |-> ##[1:700] state_q == S_STOP)
      else $error("nack did not stop");
   AST_REQ_HELD: assert property (@(posedge ref_clk_in)
      disable iff (!nrst_in) s_long_low |=> (scl_oe_out && !sda_oe_out)[*8])
      else $error("request hold broken");
   AST_NO_CAL_WRITE: assert property (@(posedge ref_clk_in)
      disable iff (!nrst_in) (state_q == S_START && op_q == THSM_OP_WRITE)
      |-> cmd_q[3:0] < `THSM_CAL_FIRST) else $error("calibration write");
   AST_ERASE_FIRST: assert property (@(posedge ref_clk_in)
      disable iff (!nrst_in) (state_q == S_BIT && stick && erase_q &&
      op_q == THSM_OP_WRITE && (idx_q == 3'h2 || idx_q == 3'h3))
      |=> sda_oe_out) else $error("erase pass sent a one");
   AST_IDLE_HIGH: assert property (@(posedge ref_clk_in)
      disable iff (!nrst_in) (state_q == S_IDLE) |=> !scl_oe_out)
      else $error("clock pulled while idle");
endmodule : thsm_master

// ### thsm_dev_model.sv
/*
 * Behavioural thermometer target: word memories, pec, pwm start-up,
 * request, sleep, wake and both clock timeouts. Assumes open-drain
 * wires resolved by the bench.
 */
`timescale 1ns/100ps
`include "thsm_regs.svh"
module thsm_dev_model #(
   parameter logic [6:0] OWN_ADDR = 7'h3A, // arbitrary bus address
   parameter real REQ_NS = 3900.0, // shortened request hold
   parameter real WAKE_NS = 1900.0, // shortened wake hold
   parameter real LOW_TO_NS = 21000000.0, // clock-low timeout
   parameter real HIGH_TO_NS = 52000.0 // clock-high timeout
) (
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic bad_pec_in,
   output logic sda_low_out,
   output logic sleeping_out
);
   logic [15:0] eep [16]; // word memory, cells 0..13 writable
   logic [15:0] ram [16]; // result memory, read only
   logic [15:0] wd; // received data word
   logic [7:0] sh, crc, tx; // shifter, running pec, send byte
   logic [3:0] ma; // word address from the command
   logic on, rd, sr, is_ram, is_slp, pend, pwm, pwmv, drv, bad, ok, slp;
   int bc, nb, nt; // bit, received byte and sent byte counts
   real t_fall, t_rise; // times of the last clock fall and rise
   initial begin
      for (int i = 0; i < 16; i++) begin
         eep[i] = 16'hA500 | 16'(i);
         ram[i] = 16'h1200 | 16'(i);
      end
      eep[0] = {9'h000, OWN_ADDR}; // own address in low bits
      eep[2] = 16'h0000; // bit zero clear selects pwm
      eep[3] = 16'h4000;
      ram[7] = 16'h8123; // temperature word with error flag
      pwm = ~eep[2][0];
      {on, rd, sr, pend, pwmv, drv, bad, slp} = '0;
      {bc, nb, nt} = '0;
      crc = `THSM_CRC_INIT;
      t_fall = 0.0;
      t_rise = 0.0;
   end
   // square wave stands in for the pwm output
   always #700 pwmv = ~pwmv;
   assign sda_low_out = drv | (pwm & pwmv);
   assign sleeping_out = slp;
   always @(posedge bad_pec_in) bad = 1'b1;
   function automatic logic [7:0] cstep(input logic [7:0] c, b);
      logic [7:0] r;
      r = c ^ b;
      for (int i = 0; i < 8; i++) begin
         r = r[7] ? {r[6:0], 1'b0} ^ `THSM_CRC_POLY : {r[6:0], 1'b0};
      end
      return r;
   endfunction : cstep
   // drop the transfer in hand and wait for a new start
   task automatic comm_reset;
      {on, rd, pend, drv} = '0;
      {nb, nt} = '0;
      crc = `THSM_CRC_INIT;
   endtask : comm_reset
   // start or repeated start, ignored in pwm and sleep
   always @(negedge sda_in) begin
      if (scl_in === 1'b1 && !pwm && !slp) begin
         sr = (nb == 2);
         if (nb == 0) on = 1'b1;
         bc = -1; // the clock fall that ends a start is no bit
         t_rise = $realtime; // high time counts from the start
      end
   end
   // stop: a queued sleep takes hold here
   always @(posedge sda_in) begin
      if (scl_in === 1'b1 && !pwm) begin
         slp = slp | pend;
         comm_reset();
      end
   end
   // long low holds leave pwm or sleep; data sampled on rise
   always @(posedge scl_in) begin
      if (on && $realtime - t_fall > LOW_TO_NS) comm_reset();
      t_rise = $realtime;
      if (pwm && $realtime - t_fall > REQ_NS) pwm = 1'b0;
      if (slp && $realtime - t_fall > WAKE_NS) slp = 1'b0;
      if (on && !rd && bc < 8) sh = {sh[6:0], sda_in};
   end
   task automatic send_next;
      logic [15:0] w;
      w = is_ram ? ram[ma] : eep[ma];
      tx = nt == 0 ? w[7:0] : nt == 1 ? w[15:8] : crc ^ {8{bad}};
      if (nt == 2) bad = 1'b0;
      crc = cstep(crc, tx);
      nt = nt + 1;
      drv = ~tx[7];
   endtask : send_next
   task automatic take_byte;
      ok = 1'b0;
      if (nb == 0) begin
         ok = !sh[0] && (sh[7:1] == eep[0][6:0] || sh[7:1] == 7'h00);
      end else if (nb == 1) begin
         ma = sh[3:0];
         is_ram = sh[7:4] == `THSM_OPC_RAM;
         is_slp = sh == `THSM_OPC_SLEEP;
         ok = is_ram || is_slp || sh[7:4] == `THSM_OPC_EEPROM;
      end else if (sr) begin
         ok = sh[0] && !is_slp;
         ok = ok && (sh[7:1] == eep[0][6:0] || sh[7:1] == 7'h00);
         rd = ok;
      end else if (is_slp || nb == 4) begin
         ok = cstep(crc, sh) == 8'h00;
         ok = ok && (is_slp || (!is_ram && ma <= 4'hD));
         pend = ok && is_slp;
         // zero erases; an unerased cell keeps old ones set
         if (ok && !is_slp) begin
            eep[ma] = (wd == 16'h0000 || eep[ma] == 16'h0000) ? wd
               : eep[ma] | wd;
         end
      end else begin
         wd = nb == 2 ? {8'h00, sh} : {sh, wd[7:0]};
         ok = 1'b1;
      end
      crc = cstep(crc, sh);
      nb = nb + 1;
      if (ok) #300 drv = 1'b1;
      else on = 1'b0; // silent for the rest
   endtask : take_byte
   // clock fall: count bits, ack, move send data
   always @(negedge scl_in) begin
      if (on && $realtime - t_rise > HIGH_TO_NS) comm_reset();
      t_fall = $realtime;
      if (on) begin
         bc = bc + 1;
         if (bc == 8 && !rd) take_byte();
         else if (bc == 8) #300 drv = 1'b0;
         else if (bc == 9) begin
            bc = 0;
            #300 drv = 1'b0;
            if (rd && nt < 3) send_next();
         end else if (rd) #300 drv = ~tx[7 - bc];
      end
   end
endmodule : thsm_dev_model

// ### thsm_master_test.sv
/*
 * Self-checking bench of the thermometer bus master with a target
 * model. Assumes the design files and thsm_dev_model compile first.
 */
`timescale 1ns/100ps
`include "thsm_regs.svh"
module thsm_master_test import thsm_pkg::*;;
   localparam logic [6:0] ADDR = 7'h3A; // model's bus address
   localparam int BIT_LOW = 2 * 63; // low cycles per bit
   logic ref_clk_in, nrst_in, cmd_valid, ram_sel, bad_pec;
   logic cmd_ready, done, rdata_err, asleep, scl_oe, sda_oe, dev_low, dev_slp;
   logic [6:0] taddr;
   logic [3:0] maddr;
   logic [15:0] wdata, rdata;
   logic scl_lvl, sda_lvl; // driven pin levels, open drain keeps them low
   thsm_op_type cmd_op;
   thsm_stat_type status;
   wire scl = !scl_oe; // pull-up, master owns the clock
   wire sda = !(sda_oe || dev_low); // wired-and data line
   int miscompares = 0, checks_done = 0, cycles = 0, busy;
   thsm_master #(.REQ_CYC(100), .WAKE_CYC(50), .SETTLE_CYC(20), .TRIES(3)) dut (
      .ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .cmd_valid_in(cmd_valid),
      .cmd_ready_out(cmd_ready), .cmd_op_in(cmd_op), .taddr_in(taddr),
      .ram_sel_in(ram_sel), .maddr_in(maddr), .wdata_in(wdata),
      .done_out(done), .status_out(status), .rdata_out(rdata),
      .rdata_err_out(rdata_err), .asleep_out(asleep), .scl_in(scl),
      .scl_out(scl_lvl), .scl_oe_out(scl_oe), .sda_in(sda),
      .sda_out(sda_lvl), .sda_oe_out(sda_oe));
   thsm_dev_model #(.OWN_ADDR(ADDR)) dev (.scl_in(scl), .sda_in(sda),
      .bad_pec_in(bad_pec), .sda_low_out(dev_low), .sleeping_out(dev_slp));
   initial begin
      ref_clk_in = 1'b0;
      forever #20 ref_clk_in = ~ref_clk_in;
   end
   task automatic test_done;
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : test_done
   // hang guard, sized above the whole run
   always @(posedge ref_clk_in) begin
      cycles++;
      if (cycles == 110000) begin
         miscompares++;
         $display("unexpected at %0t: run too long", $time);
         test_done();
      end
   end
   function automatic bit bad(input bit c);
      checks_done++;
      return c;
   endfunction : bad
   task automatic oops(input string msg);
      miscompares++;
      $display("unexpected at %0t: %s", $time, msg);
   endtask : oops
   // one request; busy counts cycles with the clock pulled low
   task automatic run(input thsm_op_type op, input logic [6:0] ta,
         input logic rs, input logic [3:0] ma, input logic [15:0] wd);
      int n;
      n = 0;
      busy = 0;
      @(posedge ref_clk_in);
      cmd_op <= op;
      taddr <= ta;
      ram_sel <= rs;
      maddr <= ma;
      wdata <= wd;
      cmd_valid <= 1'b1;
      @(posedge ref_clk_in);
      cmd_valid <= 1'b0;
      while (done !== 1'b1 && n < 40000) begin
         @(negedge ref_clk_in);
         n++;
         if (scl_oe === 1'b1) busy++;
      end
      if (bad(n >= 40000)) oops("no done");
   endtask : run
   task automatic t_request;
      run(THSM_OP_REQUEST, 7'h00, 1'b0, 4'h0, 16'h0000);
      if (bad(busy < 99 || status !== THSM_ST_OK)) oops("request hold");
      if (bad(dev.pwm !== 1'b0)) oops("still in pwm");
   endtask : t_request
   task automatic t_read_ram;
      run(THSM_OP_READ, ADDR, 1'b1, 4'h7, 16'h0000);
      if (bad(status !== THSM_ST_OK || rdata !== 16'h8123)) oops("ram read");
      if (bad(rdata_err !== 1'b1)) oops("error flag");
      if (bad(busy >= 2 * 54 * BIT_LOW)) oops("spurious retry");
   endtask : t_read_ram
   // write with erase, then a read whose first pec is spoilt
   task automatic t_write;
      run(THSM_OP_WRITE, ADDR, 1'b0, 4'h3, 16'h3999);
      if (bad(status !== THSM_ST_OK)) oops("write status");
      @(posedge ref_clk_in);
      bad_pec <= 1'b1;
      run(THSM_OP_READ, ADDR, 1'b0, 4'h3, 16'h0000);
      if (bad(status !== THSM_ST_OK || rdata !== 16'h3999)) oops("readback");
      if (bad(busy < 2 * 54 * BIT_LOW)) oops("no pec retry");
   endtask : t_write
   task automatic t_refuse;
      run(THSM_OP_WRITE, ADDR, 1'b0, 4'h5, 16'h1234);
      if (bad(status !== THSM_ST_REFUSED || busy != 0)) oops("cal write");
      if (bad(dev.eep[5] !== 16'hA505)) oops("cal cell changed");
   endtask : t_refuse
   task automatic t_absent;
      run(THSM_OP_READ, 7'h11, 1'b0, 4'h0, 16'h0000);
      if (bad(status !== THSM_ST_NACK)) oops("absent target");
      if (bad(busy < 27 * BIT_LOW || busy >= 36 * BIT_LOW)) oops("tries");
   endtask : t_absent
   // sleep by all-call, wake, then read the address cell
   task automatic t_sleep;
      run(THSM_OP_SLEEP, 7'h00, 1'b0, 4'h0, 16'h0000);
      if (bad(status !== THSM_ST_OK || asleep !== 1'b1)) oops("sleep");
      if (bad(dev_slp !== 1'b1 || scl !== 1'b1)) oops("target awake");
      run(THSM_OP_WAKE, 7'h00, 1'b0, 4'h0, 16'h0000);
      if (bad(asleep !== 1'b0 || dev_slp !== 1'b0 || busy < 49)) oops("wake");
      run(THSM_OP_READ, ADDR, 1'b0, 4'h0, 16'h0000);
      if (bad(status !== THSM_ST_OK || rdata !== {9'h000, ADDR})) oops("addr cell");
   endtask : t_sleep
   initial begin
      nrst_in = 1'b0;
      {cmd_valid, ram_sel, bad_pec} = '0;
      cmd_op = THSM_OP_READ;
      taddr = 7'h00;
      maddr = 4'h0;
      wdata = 16'h0000;
      repeat (6) @(posedge ref_clk_in);
      nrst_in <= 1'b1;
      @(negedge ref_clk_in);
      if (bad(cmd_ready !== 1'b1 || scl_oe !== 1'b0 ||
         sda_oe !== 1'b0)) oops("reset");
      if (bad(scl_lvl !== 1'b0 || sda_lvl !== 1'b0)) oops("pin level");
      t_request();
      t_read_ram();
      t_write();
      t_refuse();
      t_absent();
      t_sleep();
      test_done();
   end
endmodule : thsm_master_test
